// file: mcatx_defs.vh
// mcatx_defs.vh: constants of the multichannel two-channel-format audio serial transmitter
// assumes: included by bare name; clk is 10 MHz and all pins are synchronous to it
`ifndef MCATX_DEFS_VH
`define MCATX_DEFS_VH
`define MCATX_FMT_TDM 2'h0
`define MCATX_FMT_I2S 2'h1
`define MCATX_FMT_LJ 2'h2
`define MCATX_WLEN_RESET 2'h3
`define MCATX_NCHAN 8
`define MCATX_SLOT_W 6
`define MCATX_SAMPLE_W 32
`define MCATX_SLOTS_PER_HALF 32
`define MCATX_CLK_HZ 10000000
`define MCATX_RATE_MAX_KHZ 768
`define MCATX_BCLK_MIN_KHZ 256
`define MCATX_BCLK_MAX_KHZ 24576
`define MCATX_RATIO_MIN 16
`define MCATX_RATIO_MAX 2048
`define MCATX_BCLK_HALF_CLKS 2
`endif

// file: mcatx_slot_pick.v
// mcatx_slot_pick.v: finds the channel owning one slot of one half and picks its bit
// assumes: channel samples are MSB aligned in 32-bit words; lowest channel wins a clash
`include "mcatx_defs.vh"
`default_nettype none
module mcatx_slot_pick #(
   parameter NCHAN = `MCATX_NCHAN
) (
   // channel setup
   input wire [NCHAN-1:0] chanMask,
   input wire [NCHAN*`MCATX_SLOT_W-1:0] slotCodes,
   input wire [NCHAN*`MCATX_SAMPLE_W-1:0] samples,
   // slot being sent
   input wire [`MCATX_SLOT_W-1:0] wantCode,
   input wire [4:0] bitIdx,
   // result
   output reg owned,
   output reg bitVal
);
   integer i;
   always @* begin
      owned = 1'b0;
      bitVal = 1'b0;
      for (i = NCHAN - 1; i >= 0; i = i - 1) begin
         if (chanMask[i] && slotCodes[i*`MCATX_SLOT_W +: `MCATX_SLOT_W] == wantCode) begin
            owned = 1'b1;
            bitVal = samples[i*`MCATX_SAMPLE_W + 31 - bitIdx];
         end
      end
   end
endmodule
`default_nettype wire

// file: mcatx_top.v
// mcatx_top.v: I2S / left-justified multichannel serial transmitter with clock detection
// assumes: pins sampled on clk; bit clock well below clk/4; TDM format not served here
`include "mcatx_defs.vh"
`default_nettype none
module mcatx_top #(
   parameter NCHAN = `MCATX_NCHAN,
   parameter BCLK_HALF = `MCATX_BCLK_HALF_CLKS
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // configuration
   input wire [1:0] serialFormatSelect,
   input wire [1:0] slotWordLength,
   input wire [4:0] slotStartDelay,
   input wire [NCHAN-1:0] chanEnable,
   input wire [NCHAN*`MCATX_SLOT_W-1:0] channelSlotAssign,
   input wire tristateEnable,
   input wire busHoldEnable,
   input wire secondLaneEnable,
   input wire [NCHAN-1:0] secondLaneSelect,
   input wire daisyEnable,
   input wire latchRelief,
   input wire controllerMode,
   input wire bitClockInvert,
   input wire [10:0] halfFrameBits,
   input wire syncRequest,
   // sample data
   input wire [NCHAN*`MCATX_SAMPLE_W-1:0] sampleData,
   // bus pins
   input wire bitClockIn,
   output reg bitClockOut,
   output reg bitClockOeN,
   input wire frameSyncIn,
   output reg frameSyncOut,
   output reg frameSyncOeN,
   output reg serialDataOut,
   output reg serialDataOeN,
   output reg busKeeperOn,
   output reg generalOutputPinData,
   output reg generalOutputPinOeN,
   input wire generalInputPin,
   // detection and sampling status
   output reg [3:0] detRateIdx,
   output reg [11:0] detRatio,
   output reg detValid,
   output reg [7:0] clkDivSetting,
   output reg sampleStrobe,
   output reg syncAligned
);
   localparam [4:0] WLEN16 = 5'd15;

   function [9:0] rateKhz;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: rateKhz = 10'd8;
            4'h1: rateKhz = 10'd16;
            4'h2: rateKhz = 10'd24;
            4'h3: rateKhz = 10'd32;
            4'h4: rateKhz = 10'd48;
            4'h5: rateKhz = 10'd96;
            4'h6: rateKhz = 10'd192;
            4'h7: rateKhz = 10'd384;
            4'h8: rateKhz = 10'd768;
            default: rateKhz = 10'd0;
         endcase
      end
   endfunction

   // nearest supported rate within one eighth of its period, else 4'hF
   function [3:0] rateIdxOf;
      input [11:0] p;
      integer i;
      integer e;
      begin
         rateIdxOf = 4'hF;
         for (i = 0; i < 9; i = i + 1) begin
            e = `MCATX_CLK_HZ / (rateKhz(i[3:0]) * 1000);
            if ({20'h0, p} + (e >> 3) >= e && {20'h0, p} <= e + (e >> 3))
               rateIdxOf = i[3:0];
         end
      end
   endfunction

   function ratioOk;
      input [11:0] n;
      begin
         case (n)
            12'd16, 12'd24, 12'd32, 12'd48, 12'd64, 12'd96, 12'd128, 12'd192,
            12'd256, 12'd384, 12'd512, 12'd1024, 12'd2048: ratioOk = 1'b1;
            default: ratioOk = 1'b0;
         endcase
      end
   endfunction

   // decoded configuration
   wire fmtI2s = (serialFormatSelect == `MCATX_FMT_I2S);
   wire fmtLj = (serialFormatSelect == `MCATX_FMT_LJ);
   wire fmtOk = fmtI2s | fmtLj;
   // 32-bit words break the 4-bit step of the shorter lengths, so that code stands alone
   wire [4:0] wlenLast = (slotWordLength == 2'h3) ? 5'h1F
      : WLEN16 + {1'b0, slotWordLength, 2'b00};
   wire [5:0] startOffset = {1'b0, slotStartDelay} + {5'h0, fmtI2s}
      + {5'h0, latchRelief};

   // controller clock generation
   reg [7:0] genDiv_reg;
   reg genBclk_reg;
   reg genFs_reg;
   reg [10:0] genBit_reg;
   wire genToggle = (genDiv_reg == BCLK_HALF - 1);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         genDiv_reg <= 8'h00;
         genBclk_reg <= 1'b0;
         genFs_reg <= 1'b0;
         genBit_reg <= 11'h000;
      end else if (!controllerMode) begin
         genDiv_reg <= 8'h00;
         genBclk_reg <= 1'b0;
         genBit_reg <= 11'h000;
      end else begin
         genDiv_reg <= genToggle ? 8'h00 : genDiv_reg + 8'h01;
         if (genToggle) begin
            genBclk_reg <= ~genBclk_reg;
            if (genBclk_reg) begin
               // frame_sync flips on a falling edge only
               if (genBit_reg >= halfFrameBits - 11'h001) begin
                  genBit_reg <= 11'h000;
                  genFs_reg <= ~genFs_reg;
               end else begin
                  genBit_reg <= genBit_reg + 11'h001;
               end
            end
         end
      end
   end

   // pins of the controller role; everything lags the internal view by one clk
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         bitClockOut <= 1'b0;
         bitClockOeN <= 1'b1;
         frameSyncOut <= 1'b0;
         frameSyncOeN <= 1'b1;
      end else begin
         bitClockOut <= genBclk_reg ^ bitClockInvert;
         bitClockOeN <= ~controllerMode;
         frameSyncOut <= genFs_reg;
         frameSyncOeN <= ~controllerMode;
      end
   end

   // edge detection on the chosen clock source
   wire bclkNow = controllerMode ? genBclk_reg : (bitClockIn ^ bitClockInvert);
   wire fsNow = controllerMode ? genFs_reg : frameSyncIn;
   reg bclkPrev_reg;
   reg fsPrev_reg;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         bclkPrev_reg <= 1'b0;
         fsPrev_reg <= 1'b0;
      end else begin
         bclkPrev_reg <= bclkNow;
         fsPrev_reg <= fsNow;
      end
   end
   wire fallTick = bclkPrev_reg & ~bclkNow;
   wire fsEdge = fsNow ^ fsPrev_reg;
   wire leftHalf = fmtI2s ? ~fsNow : fsNow;
   wire frameStart = fsEdge & leftHalf;

   // slot sequencer: waits startOffset falling edges, then walks slots and bits
   reg [5:0] wait_reg;
   reg [5:0] slot_reg;
   reg [4:0] bit_reg;
   reg right_reg;
   reg seen_reg;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_reg <= 6'h00;
         slot_reg <= 6'h20;
         bit_reg <= 5'h00;
         right_reg <= 1'b0;
         seen_reg <= 1'b0;
      end else if (syncRequest) begin
         seen_reg <= 1'b0;
         slot_reg <= 6'h20;
      end else if (fsEdge) begin
         // a new half begins; LJ with no offset shows its MSB at once
         right_reg <= ~leftHalf;
         slot_reg <= 6'h00;
         bit_reg <= 5'h00;
         wait_reg <= startOffset;
         seen_reg <= 1'b1;
      end else if (fallTick) begin
         if (wait_reg != 6'h00) begin
            wait_reg <= wait_reg - 6'h01;
         end else if (slot_reg < `MCATX_SLOTS_PER_HALF) begin
            if (bit_reg == wlenLast) begin
               bit_reg <= 5'h00;
               slot_reg <= slot_reg + 6'h01;
            end else begin
               bit_reg <= bit_reg + 5'h01;
            end
         end
      end
   end
   wire sending = seen_reg & fmtOk & (wait_reg == 6'h00) & ~slot_reg[5];
   wire [5:0] wantCode = {right_reg, slot_reg[4:0]};

   // lane split: channels marked for lane two leave the primary lane
   wire [NCHAN-1:0] laneTwo = secondLaneEnable ? secondLaneSelect : {NCHAN{1'b0}};
   wire ownA;
   wire bitA;
   wire ownB;
   wire bitB;
   mcatx_slot_pick #(.NCHAN(NCHAN)) pickPrimary (
      .chanMask(chanEnable & ~laneTwo),
      .slotCodes(channelSlotAssign),
      .samples(sampleData),
      .wantCode(wantCode),
      .bitIdx(bit_reg),
      .owned(ownA),
      .bitVal(bitA)
   );
   mcatx_slot_pick #(.NCHAN(NCHAN)) pickSecond (
      .chanMask(chanEnable & laneTwo),
      .slotCodes(channelSlotAssign),
      .samples(sampleData),
      .wantCode(wantCode),
      .bitIdx(bit_reg),
      .owned(ownB),
      .bitVal(bitB)
   );

   // output drivers
   wire driveA = fmtOk & ((sending & ownA) | daisyEnable | ~tristateEnable);
   wire driveB = fmtOk & secondLaneEnable & ((sending & ownB) | ~tristateEnable);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         serialDataOut <= 1'b0;
         serialDataOeN <= 1'b1;
         busKeeperOn <= 1'b0;
         generalOutputPinData <= 1'b0;
         generalOutputPinOeN <= 1'b1;
      end else begin
         // value is held while released, which is what the keeper repeats
         if (driveA) begin
            if (sending & ownA)
               serialDataOut <= bitA;
            else if (daisyEnable)
               serialDataOut <= generalInputPin;
            else
               serialDataOut <= 1'b0;
         end
         serialDataOeN <= ~driveA;
         busKeeperOn <= busHoldEnable & ~driveA;
         if (driveB)
            generalOutputPinData <= sending & ownB & bitB;
         generalOutputPinOeN <= ~driveB;
      end
   end

   // frame measurement: clk cycles and bit clocks per frame
   reg [11:0] periodCnt_reg;
   reg [11:0] bclkCnt_reg;
   reg measArmed_reg;
   wire [3:0] rateNow = rateIdxOf(periodCnt_reg);
   wire [9:0] rateNowKhz = rateKhz(rateNow);
   wire [21:0] bclkKhz = rateNowKhz * bclkCnt_reg;
   wire detOk = (rateNow != 4'hF) & ratioOk(bclkCnt_reg)
      & (bclkKhz >= `MCATX_BCLK_MIN_KHZ) & (bclkKhz <= `MCATX_BCLK_MAX_KHZ);
   wire [31:0] divWide = `MCATX_RATE_MAX_KHZ / (rateNow == 4'hF ? 10'd1 : rateNowKhz);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         periodCnt_reg <= 12'h000;
         bclkCnt_reg <= 12'h000;
         measArmed_reg <= 1'b0;
         detRateIdx <= 4'hF;
         detRatio <= 12'h000;
         detValid <= 1'b0;
         clkDivSetting <= 8'h00;
      end else if (frameStart) begin
         periodCnt_reg <= 12'h001;
         bclkCnt_reg <= {11'h000, fallTick};
         measArmed_reg <= 1'b1;
         if (measArmed_reg) begin
            detRateIdx <= rateNow;
            detRatio <= bclkCnt_reg;
            detValid <= detOk;
            // dividers follow the detected rate with no host action
            if (detOk)
               clkDivSetting <= divWide[7:0];
         end
      end else begin
         if (periodCnt_reg != 12'hFFF)
            periodCnt_reg <= periodCnt_reg + 12'h001;
         if (fallTick && bclkCnt_reg != 12'hFFF)
            bclkCnt_reg <= bclkCnt_reg + 12'h001;
      end
   end

   // multi-device alignment: after a shared sync request every device restarts
   // its sample strobe on the same next frame start
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sampleStrobe <= 1'b0;
         syncAligned <= 1'b0;
      end else begin
         sampleStrobe <= frameStart & fmtOk & ~syncRequest;
         if (syncRequest)
            syncAligned <= 1'b0;
         else if (frameStart)
            syncAligned <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: mcatx_top_assertions.sv
// mcatx_top_assertions.sv: port checks of the serial transmitter
// assumes: bound to mcatx_top; target bit clock phases last four clk cycles, invert off
`default_nettype none
module mcatx_top_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration
   input wire logic [1:0] serialFormatSelect,
   input wire logic tristateEnable,
   input wire logic busHoldEnable,
   input wire logic secondLaneEnable,
   input wire logic controllerMode,
   input wire logic syncRequest,
   // pins
   input wire logic bitClockIn,
   input wire logic bitClockOut,
   input wire logic bitClockOeN,
   input wire logic frameSyncOut,
   input wire logic frameSyncOeN,
   input wire logic serialDataOut,
   input wire logic serialDataOeN,
   input wire logic busKeeperOn,
   input wire logic generalOutputPinOeN,
   // status
   input wire logic [11:0] detRatio,
   input wire logic detValid,
   input wire logic sampleStrobe,
   input wire logic syncAligned
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // fall seen one to three cycles back; a wider window would hide a late sequencer
   sequence fellLately;
      !$past(bitClockIn) && $past(bitClockIn, 4);
   endsequence
   sequence refusedSteady;
      serialFormatSelect[0] == serialFormatSelect[1] && $stable(serialFormatSelect);
   endsequence
   chk_data_on_fall: assert property (
      !controllerMode && !$past(controllerMode, 4) && !serialDataOeN
      && !$past(serialDataOeN) && $changed(serialDataOut) |-> fellLately)
      else $error("data moved off a bit clock fall");
   chk_fs_on_fall: assert property (
      controllerMode && $past(controllerMode) && !frameSyncOeN && $changed(frameSyncOut)
      |-> $fell(bitClockOut))
      else $error("frame sync moved off a bit clock fall");
   chk_clock_role: assert property (
      !$past(rst) |-> bitClockOeN == !$past(controllerMode)
      && frameSyncOeN == !$past(controllerMode))
      else $error("clock pin drive wrong for role");
   chk_keeper_flag: assert property (
      !$past(rst) |-> busKeeperOn == (serialDataOeN && $past(busHoldEnable)))
      else $error("keeper flag wrong");
   chk_keeper_hold: assert property (
      busKeeperOn && $past(busKeeperOn) |-> $stable(serialDataOut))
      else $error("held data moved");
   chk_refused_fmt: assert property (
      refusedSteady |-> serialDataOeN && generalOutputPinOeN && !sampleStrobe)
      else $error("refused format still active");
   chk_drive_kept: assert property (
      !tristateEnable && !$past(tristateEnable) && serialFormatSelect == 2'h2
      && $stable(serialFormatSelect) && !$past(serialDataOeN) |-> !serialDataOeN)
      else $error("data released with release option off");
   chk_lane_idle: assert property (
      !secondLaneEnable && !$past(secondLaneEnable) |-> generalOutputPinOeN)
      else $error("second lane driven while off");
   chk_strobe_single: assert property (
      sampleStrobe |=> !sampleStrobe)
      else $error("strobe longer than one cycle");
   chk_sync_clear: assert property (
      syncRequest |=> !syncAligned)
      else $error("alignment flag not cleared");
   chk_ratio_range: assert property (
      detValid |-> detRatio >= 12'h010 && detRatio <= 12'h800)
      else $error("valid flag on unsupported ratio");
endmodule
bind mcatx_top mcatx_top_assertions u_chk (
   .clk, .rst, .serialFormatSelect, .tristateEnable, .busHoldEnable, .secondLaneEnable,
   .controllerMode, .syncRequest, .bitClockIn, .bitClockOut, .bitClockOeN, .frameSyncOut,
   .frameSyncOeN, .serialDataOut, .serialDataOeN, .busKeeperOn, .generalOutputPinOeN,
   .detRatio, .detValid, .sampleStrobe, .syncAligned
);
`default_nettype wire

// file: mcatx_host_model.sv
// mcatx_host_model.sv: host port making bit clock and frame sync, latching data bits
// assumes: clk-synchronous pins; bit clock phases of H clk cycles, HB bits per frame sync half
`default_nettype none
module mcatx_host_model #(
   parameter int H = 4,
   parameter int HB = 100
) (
   // clock
   input wire logic clk,
   input wire logic rst,
   input wire logic leftHigh,
   // pins
   output logic bitClock,
   output logic frameSync,
   input wire logic dataMain,
   input wire logic dataMainOeN,
   input wire logic dataSide,
   input wire logic dataSideOeN,
   // captured bits
   output logic frameStart,
   output logic rxStrobe,
   output logic [7:0] rxIdx,
   output logic [3:0] rxBits
);
   logic [3:0] phaseCnt;
   logic [7:0] bitCnt;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phaseCnt <= 4'h0;
         bitCnt <= 8'h00;
         bitClock <= 1'b1;
         frameSync <= 1'b0;
         frameStart <= 1'b0;
         rxStrobe <= 1'b0;
         rxIdx <= 8'h00;
         rxBits <= 4'h0;
      end else begin
         phaseCnt <= (phaseCnt == 4'(2 * H - 1)) ? 4'h0 : phaseCnt + 4'h1;
         frameStart <= 1'b0;
         rxStrobe <= (phaseCnt == 4'(H - 1));
         if (phaseCnt == 4'(H - 1)) begin
            // data is latched on the rising edge, a full phase after the falling edge that moves it
            bitClock <= 1'b1;
            rxIdx <= bitCnt;
            bitCnt <= bitCnt + 8'h01;
            rxBits <= {dataMain, !dataMainOeN, dataSide, !dataSideOeN};
         end
         if (phaseCnt == 4'(2 * H - 1)) begin
            bitClock <= 1'b0;
            if (bitCnt == 8'(HB)) begin
               frameSync <= !frameSync;
               frameStart <= (!frameSync == leftHigh);
               bitCnt <= 8'h00;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: tb.sv
// tb.sv: self-checking bench, host model clocks the bus and collects bits
// assumes: checker bound from its own file; target role except one stretch
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] fmt = 2'h2;
   logic [1:0] wlen = 2'h3;
   logic [4:0] dly = 5'h00;
   logic [47:0] slots = 48'h0;
   logic triEn = 1'b1;
   logic holdEn = 1'b0;
   logic laneEn = 1'b0;
   logic [7:0] laneSel = 8'h00;
   logic relief = 1'b0;
   logic ctrl = 1'b0;
   logic syncReq = 1'b0;
   logic daisy = 1'b0;
   logic gpi = 1'b0;
   logic [255:0] smp = 256'h0;
   wire sdo, sdoOeN, gpo, gpoOeN, bclk, fs, frameStart, rxStrobe, detValid;
   wire [3:0] rxBits;
   wire [7:0] rxIdx;
   wire [11:0] detRatio;
   wire [3:0] detRateIdx;
   wire [7:0] clkDiv;
   int err_count = 0;
   int comparisons = 0;
   int seed = 84281;
   logic monOn = 1'b0;
   logic [11:0] notes[$];
   always #50 clk = ~clk;
   mcatx_top dut (
      .clk, .rst, .serialFormatSelect(fmt), .slotWordLength(wlen), .slotStartDelay(dly),
      .chanEnable(8'h07), .channelSlotAssign(slots), .tristateEnable(triEn),
      .busHoldEnable(holdEn), .secondLaneEnable(laneEn), .secondLaneSelect(laneSel),
      .daisyEnable(daisy), .latchRelief(relief), .controllerMode(ctrl), .bitClockInvert(1'b0),
      .halfFrameBits(11'h008), .syncRequest(syncReq), .sampleData(smp), .bitClockIn(bclk),
      .bitClockOut(), .bitClockOeN(), .frameSyncIn(fs), .frameSyncOut(), .frameSyncOeN(),
      .serialDataOut(sdo), .serialDataOeN(sdoOeN), .busKeeperOn(), .generalOutputPinData(gpo),
      .generalOutputPinOeN(gpoOeN), .generalInputPin(gpi), .detRateIdx, .detRatio,
      .detValid, .clkDivSetting(clkDiv), .sampleStrobe(), .syncAligned()
   );
   mcatx_host_model host (
      .clk, .rst, .leftHigh(fmt == 2'h2), .bitClock(bclk), .frameSync(fs), .dataMain(sdo),
      .dataMainOeN(sdoOeN), .dataSide(gpo), .dataSideOeN(gpoOeN), .frameStart, .rxStrobe,
      .rxIdx, .rxBits
   );
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic pop_check(input logic [11:0] seen);
      check(seen, notes.size() ? notes.pop_front() : 12'hFFF);
   endtask
   task automatic tally_and_finish;
      if (err_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_frame;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!frameStart && n < 4000);
      // a frame that never comes is a failure, not a silent skip
      if (!frameStart)
         err_count++;
   endtask
   always @(posedge clk) begin
      if (monOn && rxStrobe && rxBits[2])
         pop_check({3'h0, rxIdx, rxBits[3]});
      if (monOn && rxStrobe && rxBits[0])
         pop_check({3'h1, rxIdx, rxBits[1]});
   end
   initial begin
      int c, i, w, off, k;
      logic lane, own, side, bitv;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (c = 0; c < 10; c++) begin
         wait_frame();
         // settings move just after a frame edge, so the next frame runs clean
         fmt <= (c > 7) ? ((c == 8) ? 2'h0 : 2'h3) : (c[0] ? 2'h1 : 2'h2);
         wlen <= c[2:1];
         dly <= (c == 7) ? 5'h1F : ((c == 0) ? 5'h00 : 5'($random(seed)));
         relief <= 1'($random(seed));
         laneEn <= 1'($random(seed));
         lane = 1'($random(seed));
         laneSel <= {5'h00, lane, lane, 1'b0};
         holdEn <= 1'($random(seed));
         // no daisy while the sync request aborts a half: the line would move off a fall
         daisy <= (c != 3) && 1'($random(seed));
         gpi <= 1'($random(seed));
         slots <= {30'($random(seed)), 6'h21, 6'h21, 6'h00};
         for (i = 0; i < 8; i++)
            smp[32*i +: 32] <= $random(seed);
         triEn <= (c != 4);
         if (c == 3) begin
            repeat (20) @(posedge clk);
            syncReq <= 1'b1;
            @(posedge clk);
            syncReq <= 1'b0;
         end
         if (c == 6) begin
            ctrl <= 1'b1;
            repeat (600) @(posedge clk);
            ctrl <= 1'b0;
         end
         wait_frame();
         triEn <= 1'b1;
         w = (wlen == 2'h3) ? 32 : 16 + 4 * wlen;
         off = dly + relief + (fmt == 2'h1);
         // one pass over both halves; unowned bit clocks carry the daisy input if enabled
         if (fmt == 2'h1 || fmt == 2'h2)
            for (i = 0; i < 200; i++) begin
               k = i % 100 - off - (i / 100) * w;
               own = (k >= 0 && k < w);
               side = (i >= 100 && laneEn && laneSel[1]);
               bitv = own ? smp[(i < 100) ? 31 - k : 63 - k] : 1'b0;
               if (own && !side)
                  notes.push_back({3'h0, 8'(i % 100), bitv});
               else if (daisy)
                  notes.push_back({3'h0, 8'(i % 100), gpi});
               if (own && side)
                  notes.push_back({3'h1, 8'(i % 100), bitv});
            end
         monOn = 1'b1;
         wait_frame();
         monOn = 1'b0;
         check(12'(notes.size()), 12'h000);
         notes.delete();
      end
      check(detRatio, 12'h0C8);
      check({11'h000, detValid}, 12'h000);
      check({8'h00, detRateIdx}, 12'h00F);
      check({4'h0, clkDiv}, 12'h000);
      tally_and_finish();
   end
   initial begin
      #7000000;
      err_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
